// ---- hw/scgr_regs.vh ----
/*
  Register offsets, field positions and reset values for the safety,
  checksum and amplifier gain register bank.
  Assumes a 16-bit register port addressed by printed register offset.
*/
`ifndef SCGR_REGS_VH
`define SCGR_REGS_VH

`define SCGR_ADDR_W            10
`define SCGR_DATA_W            16

`define SCGR_OFS_ERR_CLEAR     10'h080
`define SCGR_OFS_ERR_MASK      10'h081
`define SCGR_OFS_ERR_SUMMARY   10'h082
`define SCGR_OFS_FAULT_CODE    10'h083
`define SCGR_OFS_CSUM_LOW      10'h084
`define SCGR_OFS_CSUM_HIGH     10'h085
`define SCGR_OFS_RM_START      10'h086
`define SCGR_OFS_RM_FINISHED   10'h087
`define SCGR_OFS_RM_LOW        10'h088
`define SCGR_OFS_RM_HIGH       10'h089
`define SCGR_OFS_FRONT_GAIN    10'h100
`define SCGR_OFS_SECOND_GAIN   10'h101
`define SCGR_OFS_IRQ_STATUS    10'h090
`define SCGR_OFS_IRQ_ENABLE    10'h091
`define SCGR_OFS_IRQ_CLEAR     10'h092

`define SCGR_FAULT_W           6
`define SCGR_BIT_CLOCK_LOSS    5
`define SCGR_BIT_NEG_BIAS      4
`define SCGR_BIT_POS_BIAS      3
`define SCGR_BIT_REFERENCE     2
`define SCGR_BIT_OVER_TEMP     1
`define SCGR_BIT_CHECKSUM      0

`define SCGR_IRQ_W             2
`define SCGR_IRQ_FAULT         0
`define SCGR_IRQ_RM_DONE       1

`define SCGR_RESET_VALUE       16'h0000
`define SCGR_RM_WORDS          4
`define SCGR_CRC_POLY          16'h1021
`define SCGR_CRC_SEED          16'hFFFF

`endif

// ---- hw/scgr_bank.v ----
/*
  Safety error, checksum and amplifier gain register bank.
  Assumes fault inputs from analogue monitors in other clock domains,
  a 16-bit checksum result from the data path on this clock, and a
  single-cycle register port: read data appear the cycle after the strobe.
*/
// Local design decision: the address-and-strobe port.
// Notes on behaviour
// - Summary bit 0 high when any error present.
// - Fault code bits five down to zero.
// - Checksum result as low and high byte.
// - Start bit zero enables, one disables.
// - Finished bit set when map checksum done.
// - Map checksum result as low/high byte.
// - Four 2-bit front gain fields per channel.
// - Front gain codes select 2,4,8,16.
// - Four 2-bit second gain fields per channel.
// - Second gain codes select 1.4 to 11.2.
// - Every bank register resets to zero.
// - Clear control high suppresses error reporting.
// - Masked causes excluded from error reporting.
`timescale 1ns/1ps
`include "scgr_regs.vh"

module scgr_bank #(
  parameter ADDR_W = `SCGR_ADDR_W,
  parameter DATA_W = `SCGR_DATA_W
) (
  input  wire              clock,
  input  wire              arst_n,
  input  wire [ADDR_W-1:0] addr,
  input  wire [DATA_W-1:0] wdata,
  input  wire              wr_en,
  input  wire              rd_en,
  output reg  [DATA_W-1:0] rdata,
  input  wire              clock_loss_fault,
  input  wire              negative_bias_fault,
  input  wire              positive_bias_fault,
  input  wire              reference_voltage_fault,
  input  wire              over_temperature_fault,
  input  wire              checksum_fault,
  input  wire [15:0]       checksum_value,
  output reg  [7:0]        front_amp_gain,
  output reg  [7:0]        second_amp_gain,
  output reg               safety_error_out,
  output reg               irq
);

  localparam FW = `SCGR_FAULT_W;
  localparam IW = `SCGR_IRQ_W;

  // Map checksum engine states, one-hot.
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RUN  = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  function hit;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // One CRC-16 step over a whole 16-bit word, bit serial in a loop.
  function [15:0] crc_word;
    input [15:0] crc;
    input [15:0] data;
    integer i;
    reg [15:0] c;
    begin
      c = crc;
      for (i = 15; i >= 0; i = i - 1) begin
        if (c[15] ^ data[i]) begin
          c = {c[14:0], 1'b0} ^ `SCGR_CRC_POLY;
        end else begin
          c = {c[14:0], 1'b0};
        end
      end
      crc_word = c;
    end
  endfunction

  wire wr_clear   = wr_en & hit(addr, `SCGR_OFS_ERR_CLEAR);
  wire wr_mask    = wr_en & hit(addr, `SCGR_OFS_ERR_MASK);
  wire wr_start   = wr_en & hit(addr, `SCGR_OFS_RM_START);
  wire wr_front   = wr_en & hit(addr, `SCGR_OFS_FRONT_GAIN);
  wire wr_second  = wr_en & hit(addr, `SCGR_OFS_SECOND_GAIN);
  wire wr_ien     = wr_en & hit(addr, `SCGR_OFS_IRQ_ENABLE);
  wire wr_iclr    = wr_en & hit(addr, `SCGR_OFS_IRQ_CLEAR);

  reg            err_clear;
  reg [FW-1:0]   err_mask;
  reg [FW-1:0]   fault_code;
  reg            rm_start;
  reg            rm_finished;
  reg [15:0]     rm_crc;
  reg [15:0]     csum;
  reg [2:0]      state;
  reg [1:0]      word_idx;
  reg [IW-1:0]   irq_status;
  reg [IW-1:0]   irq_enable;
  reg [FW-1:0]   sync1;
  reg [FW-1:0]   sync2;

  wire [FW-1:0] fault_raw = {clock_loss_fault, negative_bias_fault, positive_bias_fault,
                             reference_voltage_fault, over_temperature_fault,
                             checksum_fault};

  // Fault inputs come from asynchronous monitors, so each passes two flops.
  // A fault that lasts less than one clock period may be missed by
  // the first flop; the monitors are expected to hold a fault longer.
  genvar g;
  generate
    for (g = 0; g < FW; g = g + 1) begin : g_sync
      always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          sync1[g] <= 1'b0;
        end else begin
          sync1[g] <= fault_raw[g];
        end
      end

      always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          sync2[g] <= 1'b0;
        end else begin
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate

  wire [FW-1:0] fault_seen = sync2 & ~err_mask;
  wire          any_fault  = |fault_code;

  // Words covered by the map checksum: error mask, error clear and the two gain registers.
  // The words are read live while the run goes on, so a write during the
  // four run cycles is folded into the result; software should not write then.
  reg [15:0] map_word;
  always @* begin
    case (word_idx)
      2'd0: begin
        map_word = {{(16-FW){1'b0}}, err_mask};
      end
      2'd1: begin
        map_word = {15'h0000, err_clear};
      end
      2'd2: begin
        map_word = {8'h00, front_amp_gain};
      end
      default: begin
        map_word = {8'h00, second_amp_gain};
      end
    endcase
  end

  // Each control register has a process of its own, so that the write
  // decode of one register cannot disturb the value of another.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      err_clear <= 1'b0;
    end else if (wr_clear) begin
      err_clear <= wdata[0];
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      err_mask <= {FW{1'b0}};
    end else if (wr_mask) begin
      err_mask <= wdata[FW-1:0];
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rm_start <= 1'b0;
    end else if (wr_start) begin
      rm_start <= wdata[0];
    end
  end

  // The four gain pairs are independent channel fields.
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_gain
      always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          front_amp_gain[2*ch+1:2*ch] <= 2'b00;
        end else if (wr_front) begin
          front_amp_gain[2*ch+1:2*ch] <= wdata[2*ch+1:2*ch];
        end
      end

      always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          second_amp_gain[2*ch+1:2*ch] <= 2'b00;
        end else if (wr_second) begin
          second_amp_gain[2*ch+1:2*ch] <= wdata[2*ch+1:2*ch];
        end
      end
    end
  endgenerate

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_enable <= {IW{1'b0}};
    end else if (wr_ien) begin
      irq_enable <= wdata[IW-1:0];
    end
  end

  // The data-path checksum is on this clock and is copied every cycle.
  // The two bytes are not latched together, so a change between the two
  // reads can mix halves of different results.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      csum <= 16'h0000;
    end else begin
      csum <= checksum_value;
    end
  end

  // While clear is held nothing is reported; otherwise bits accumulate.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fault_code <= {FW{1'b0}};
    end else if (err_clear) begin
      fault_code <= {FW{1'b0}};
    end else begin
      fault_code <= fault_code | fault_seen;
    end
  end

  // Start bit low means enabled, as the polarity is defined; a run happens
  // on each transition into the enabled level seen in the idle state, and on leaving reset.
  reg start_prev;
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state       <= ST_IDLE;
      start_prev  <= 1'b1;
      word_idx    <= 2'd0;
      rm_crc      <= 16'h0000;
      rm_finished <= 1'b0;
    end else begin
      start_prev <= rm_start;
      case (state)
        ST_IDLE: begin
          if (!rm_start && start_prev) begin
            state       <= ST_RUN;
            word_idx    <= 2'd0;
            rm_crc      <= `SCGR_CRC_SEED;
            rm_finished <= 1'b0;
          end
        end
        ST_RUN: begin
          rm_crc <= crc_word(rm_crc, map_word);
          if (word_idx == `SCGR_RM_WORDS - 1) begin
            state <= ST_DONE;
          end else begin
            word_idx <= word_idx + 2'd1;
          end
        end
        ST_DONE: begin
          rm_finished <= 1'b1;
          state       <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Set wins over a clear written in the same cycle.
  wire [IW-1:0] irq_set;
  assign irq_set[`SCGR_IRQ_FAULT]   = any_fault & ~safety_error_out;
  assign irq_set[`SCGR_IRQ_RM_DONE] = (state == ST_DONE);

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= {IW{1'b0}};
    end else begin
      irq_status <= (irq_status & ~(wr_iclr ? wdata[IW-1:0] : {IW{1'b0}})) | irq_set;
    end
  end

  // The interrupt pin lags the status by one cycle so that it is a flop.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      safety_error_out <= 1'b0;
    end else begin
      safety_error_out <= any_fault;
    end
  end

  // Read data stand for one cycle and return to zero, so an idle port
  // shows no stale register contents. Write-only interrupt clear reads as zero.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= `SCGR_RESET_VALUE;
    end else if (rd_en) begin
      case (addr)
        `SCGR_OFS_ERR_CLEAR: begin
          rdata <= {15'h0000, err_clear};
        end
        `SCGR_OFS_ERR_MASK: begin
          rdata <= {{(16-FW){1'b0}}, err_mask};
        end
        `SCGR_OFS_ERR_SUMMARY: begin
          rdata <= {15'h0000, any_fault};
        end
        `SCGR_OFS_FAULT_CODE: begin
          rdata <= {{(16-FW){1'b0}}, fault_code};
        end
        `SCGR_OFS_CSUM_LOW: begin
          rdata <= {8'h00, csum[7:0]};
        end
        `SCGR_OFS_CSUM_HIGH: begin
          rdata <= {8'h00, csum[15:8]};
        end
        `SCGR_OFS_RM_START: begin
          rdata <= {15'h0000, rm_start};
        end
        `SCGR_OFS_RM_FINISHED: begin
          rdata <= {15'h0000, rm_finished};
        end
        `SCGR_OFS_RM_LOW: begin
          rdata <= {8'h00, rm_crc[7:0]};
        end
        `SCGR_OFS_RM_HIGH: begin
          rdata <= {8'h00, rm_crc[15:8]};
        end
        `SCGR_OFS_FRONT_GAIN: begin
          rdata <= {8'h00, front_amp_gain};
        end
        `SCGR_OFS_SECOND_GAIN: begin
          rdata <= {8'h00, second_amp_gain};
        end
        `SCGR_OFS_IRQ_STATUS: begin
          rdata <= {{(16-IW){1'b0}}, irq_status};
        end
        `SCGR_OFS_IRQ_ENABLE: begin
          rdata <= {{(16-IW){1'b0}}, irq_enable};
        end
        default: begin
          rdata <= 16'h0000;
        end
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule

// ---- bench/scgr_bank_asserts.sv ----
/*
  Port checker for the register bank.
  Assumes it is bound to scgr_bank and sees only that module's ports.
*/
`timescale 1ns/1ps
module scgr_bank_asserts #(
  parameter ADDR_W = 10,
  parameter DATA_W = 16
) (
  input wire              clock,
  input wire              arst_n,
  input wire [ADDR_W-1:0] addr,
  input wire [DATA_W-1:0] wdata,
  input wire              wr_en,
  input wire              rd_en,
  input wire [DATA_W-1:0] rdata,
  input wire [7:0]        front_amp_gain,
  input wire [7:0]        second_amp_gain,
  input wire              safety_error_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  chk_front_write: assert property (wr_en && addr == 10'h100 |=>
    front_amp_gain == $past(wdata[7:0])) else $error("front gain write lost");
  chk_front_hold: assert property (!(wr_en && addr == 10'h100) |=>
    $stable(front_amp_gain)) else $error("front gain moved without write");
  chk_second_write: assert property (wr_en && addr == 10'h101 |=>
    second_amp_gain == $past(wdata[7:0])) else $error("second gain write lost");
  chk_summary_read: assert property (rd_en && addr == 10'h082 |=>
    rdata[15:1] == 15'h0000) else $error("summary upper bits set");
  chk_fault_read: assert property (rd_en && addr == 10'h083 |=>
    rdata[15:6] == 10'h000) else $error("fault code upper bits set");
  chk_csum_high: assert property (rd_en && addr == 10'h085 |=>
    rdata[15:8] == 8'h00) else $error("checksum high byte too wide");
  chk_start_read: assert property (rd_en && addr == 10'h086 |=>
    rdata[15:1] == 15'h0000) else $error("start control upper bits set");
  chk_done_read: assert property (rd_en && addr == 10'h087 |=>
    rdata[15:1] == 15'h0000) else $error("finished flag upper bits set");
  chk_map_high: assert property (rd_en && addr == 10'h089 |=>
    rdata[15:8] == 8'h00) else $error("map checksum high byte too wide");
  chk_clear_quiet: assert property (wr_en && addr == 10'h080 && wdata[0] |=>
    ##2 !safety_error_out) else $error("error reported while clear held");

  cover property (rd_en && addr == 10'h083);
  cover property (safety_error_out);
  cover property (wr_en && addr == 10'h080 && wdata[0]);
endmodule

// ---- bench/scgr_bank_bench.sv ----
/*
  Self-checking bench for the register bank.
  Assumes the design header is on the include path.
*/
`timescale 1ns/1ps
module scgr_bank_bench;
  reg         clock = 1'b0;
  reg         arst_n = 1'b0;
  reg  [9:0]  addr = 10'h000;
  reg  [15:0] wdata = 16'h0000;
  reg         wr_en = 1'b0;
  reg         rd_en = 1'b0;
  reg  [5:0]  flt = 6'h00;
  reg  [15:0] csum = 16'h0000;
  reg  [15:0] v;
  wire [15:0] rdata;
  wire [7:0]  front;
  wire [7:0]  second;
  wire        err_out;
  wire        irq;
  int         fails = 0;
  int         n_tests = 0;
  int         cycles = 0;
  int         i;
  reg  [9:0]  zl [0:6] = '{10'h082, 10'h083, 10'h084, 10'h085, 10'h086, 10'h100, 10'h101};

  always #50 clock = ~clock;

  scgr_bank dut (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .clock_loss_fault(flt[5]), .negative_bias_fault(flt[4]),
    .positive_bias_fault(flt[3]), .reference_voltage_fault(flt[2]),
    .over_temperature_fault(flt[1]), .checksum_fault(flt[0]), .checksum_value(csum),
    .front_amp_gain(front), .second_amp_gain(second), .safety_error_out(err_out), .irq(irq));

  task check(input [15:0] got, input [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input [9:0] a, input [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task rd(input [9:0] a, output [15:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask

  task rdc(input [9:0] a, input [15:0] e);
    reg [15:0] d;
    rd(a, d);
    check(d, e);
  endtask

  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      conclude;
    end
  end

  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    for (i = 0; i < 7; i++) rdc(zl[i], 16'h0000);
    wr(10'h100, 16'h00E4);
    rdc(10'h100, 16'h00E4);
    check(front, 8'hE4);
    wr(10'h101, 16'h001B);
    rdc(10'h101, 16'h001B);
    check(second, 8'h1B);
    wr(10'h083, 16'h003F);
    rdc(10'h083, 16'h0000);
    rdc(10'h3FF, 16'h0000);
    @(posedge clock);
    csum <= 16'hA55A;
    rdc(10'h084, 16'h005A);
    rdc(10'h085, 16'h00A5);
    wr(10'h086, 16'h0001);
    rdc(10'h086, 16'h0001);
    wr(10'h086, 16'h0000);
    v = 16'h0000;
    for (i = 0; i < 20 && v !== 16'h0001; i++) rd(10'h087, v);
    check(v, 16'h0001);
    rd(10'h089, v);
    wr(10'h092, 16'h0003);
    wr(10'h091, 16'h0001);
    // Pulses are short so the sticky latch, not the live level, is seen.
    for (i = 0; i < 6; i++) begin
      @(posedge clock);
      flt <= 6'h01 << i;
      repeat (2) @(posedge clock);
      flt <= 6'h00;
      repeat (4) @(posedge clock);
      rdc(10'h083, 16'h0001 << i);
      rdc(10'h082, 16'h0001);
      check(irq, 1'b1);
      wr(10'h092, 16'h0003);
      wr(10'h080, 16'h0001);
      rdc(10'h083, 16'h0000);
      check(err_out, 1'b0);
      wr(10'h080, 16'h0000);
    end
    check(irq, 1'b0);
    wr(10'h091, 16'h0000);
    wr(10'h081, 16'h0020);
    @(posedge clock);
    flt <= 6'h21;
    repeat (3) @(posedge clock);
    flt <= 6'h00;
    repeat (4) @(posedge clock);
    rdc(10'h083, 16'h0001);
    rdc(10'h090, 16'h0001);
    check(irq, 1'b0);
    conclude;
  end
endmodule

bind scgr_bank scgr_bank_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.clock, .arst_n,
  .addr, .wdata, .wr_en, .rd_en, .rdata, .front_amp_gain, .second_amp_gain, .safety_error_out);
